// File: design/dbgwp_params.svh
// Purpose: constants for the breakpoint / watchpoint debug control block
// Assumes: 5-bit scan-chain register address, 32-bit data field
// Notes:   definitions only
`ifndef DBGWP_PARAMS_SVH
`define DBGWP_PARAMS_SVH

// scan-chain register addresses
`define DBGWP_ADDR_CTRL    5'h00
`define DBGWP_ADDR_WP0     2'h1
`define DBGWP_ADDR_WP1     2'h2
// per-unit register index in the low three address bits
`define DBGWP_IDX_AV       3'h0
`define DBGWP_IDX_AM       3'h1
`define DBGWP_IDX_DV       3'h2
`define DBGWP_IDX_DM       3'h3
`define DBGWP_IDX_CV       3'h4
`define DBGWP_IDX_CM       3'h5

// debug control fields
`define DBGWP_CTRL_W       6
`define DBGWP_CTRL_RESET   6'h00
`define DBGWP_CTRL_RSV_MSK 6'h37
`define DBGWP_CB_DISABLE   5
`define DBGWP_CB_MONITOR   4
`define DBGWP_CB_RESERVED  3
`define DBGWP_CB_INT_INH   2
`define DBGWP_CB_HALT_REQ  1
`define DBGWP_CB_HALT_ACK  0

// watchpoint control value / mask fields
`define DBGWP_C_WRITE_DIR  0
`define DBGWP_C_SIZE_LO    1
`define DBGWP_C_SIZE_HI    2
`define DBGWP_C_DATA_ACC   3
`define DBGWP_C_PRIV       4
`define DBGWP_C_EXTERN     5
`define DBGWP_C_CHAIN      6
`define DBGWP_C_RANGE      7
`define DBGWP_C_ENABLE     8

// number of bits synchronised into the core domain
`define DBGWP_SYNC_BITS    6

`endif

// File: design/dbgwp_pkg.sv
// Purpose: shared types of the breakpoint / watchpoint debug control block
// Assumes: dbgwp_params.svh constants
// Notes:   types only
package dbgwp_pkg;

    // one watchpoint unit's programmed registers
    typedef struct packed {
        logic [31:0] addr_val;
        logic [31:0] addr_mask;
        logic [31:0] data_val;
        logic [31:0] data_mask;
        logic [8:0]  ctrl_val;
        logic [7:0]  ctrl_mask;
    } dbgwp_regs_t;

    // core bus activity seen by the comparators
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic        data_access_flag;
        logic        write_direction_flag;
        logic [1:0]  access_size_code;
        logic        privileged_access_flag;
        logic        fetch_16bit;
    } dbgwp_bus_t;

    // one scan-chain register access, taken at update
    typedef struct packed {
        logic        write;
        logic [4:0]  addr;
        logic [31:0] data;
    } dbgwp_scan_t;

endpackage

// File: design/dbgwp_unit.sv
// Purpose: one watchpoint comparator unit, core-clock domain
// Assumes: registers are quasi-static while the comparator is in use
// Notes:   chain output is a register loaded on an address/control match
`timescale 1ns/10ps
`default_nettype none
`include "dbgwp_params.svh"

module dbgwp_unit
    import dbgwp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  var  dbgwp_regs_t regs,       // programmed value / mask set
    input  var  dbgwp_bus_t  bus,        // core bus activity
    input  wire logic        extern_in,  // external condition input
    input  wire logic        chain_in,   // chain from the other unit
    input  wire logic        range_in,   // range from the other unit
    output logic             match,      // full match, enable applied
    output logic             range_out,  // address/control field match
    output logic             chain_out   // registered data-field match
);

    logic [7:0]  ctrl_in;    // combined control bus
    logic [31:0] data_in;    // data bus as compared
    logic        ac_ok;      // address and low control bits match
    logic        dc_ok;      // data and high control bits match

    // gather the control inputs in the value register layout
    always_comb
    begin
        ctrl_in                        = 8'h00;
        ctrl_in[`DBGWP_C_WRITE_DIR]    = bus.write_direction_flag;
        ctrl_in[`DBGWP_C_SIZE_HI:`DBGWP_C_SIZE_LO] = bus.access_size_code;
        ctrl_in[`DBGWP_C_DATA_ACC]     = bus.data_access_flag;
        ctrl_in[`DBGWP_C_PRIV]         = bus.privileged_access_flag;
        ctrl_in[`DBGWP_C_EXTERN]       = extern_in;
        ctrl_in[`DBGWP_C_CHAIN]        = chain_in;
        ctrl_in[`DBGWP_C_RANGE]        = range_in;
    end

    // 16-bit fetch: only the valid half counts, so replicate it over both halves
    always_comb
    begin
        if (bus.fetch_16bit)
        begin
            data_in = bus.addr[1] ? {bus.data[31:16], bus.data[31:16]}
                                  : {bus.data[15:0], bus.data[15:0]};
        end
        else
        begin
            data_in = bus.data;
        end
    end

    // xnor mask: a set mask bit always matches, a clear one needs equality
    assign ac_ok = &(({regs.addr_val, regs.ctrl_val[4:0]} ~^ {bus.addr, ctrl_in[4:0]})
                    | {regs.addr_mask, regs.ctrl_mask[4:0]});
    assign dc_ok = &(({regs.data_val, regs.ctrl_val[7:5]} ~^ {data_in, ctrl_in[7:5]})
                    | {regs.data_mask, regs.ctrl_mask[7:5]});

    // enable bit cannot be masked
    assign match     = ac_ok & dc_ok & regs.ctrl_val[`DBGWP_C_ENABLE];
    assign range_out = ac_ok;

    // chain register written whenever address/control matches
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            chain_out <= 1'b0;
        end
        else if (ac_ok)
        begin
            chain_out <= dc_ok;
        end
    end

endmodule // dbgwp_unit
`default_nettype wire

// File: design/dbgwp_top.sv
// Purpose: debug control register and two watchpoint units of a core
// Assumes: the tap controller sits outside and gives update and idle strobes on tck
// Notes:   registers live on tck, comparison and halt logic on the core clock
`timescale 1ns/10ps
`default_nettype none
`include "dbgwp_params.svh"

module dbgwp_top
    import dbgwp_pkg::*;
(
    input  wire logic        clk,                    // core clock
    input  wire logic        reset,                  // async, both domains
    input  wire logic        tck,                    // scan-chain clock
    input  wire logic        scan_update,            // tap in update-dr, tck pulse
    input  wire logic        scan_run_idle,          // tap in run-test/idle, tck level
    input  var  dbgwp_scan_t scan_req,               // access shifted in
    output logic [31:0]      scan_rdata,             // read data for next shift
    input  var  dbgwp_bus_t  core_bus,               // core bus activity, clk
    input  wire logic [1:0]  extern_in,              // external watch conditions, clk
    input  wire logic        ext_halt_request,       // halt request pin
    input  wire logic        core_halt_ack_int,      // core internal acknowledge, clk
    output logic             halt_request,           // request into the core
    output logic             halt_acknowledge,       // acknowledge seen outside
    output logic             core_interrupt_permit,  // interrupt permit to core
    output logic             break_halt,             // hit, enter halted debug, pulse
    output logic             break_abort             // hit, take abort, pulse
);

    // tck-domain state
    logic [`DBGWP_CTRL_W-1:0] ctrl_q;        // debug control register
    logic                     req_latch_q;   // halt request held for idle
    dbgwp_regs_t              wp_q [2];      // watchpoint registers
    logic [2:0]               dis_back_q;    // bit 5 returning to tck
    logic                     dis_tck_q;     // bit 5 as seen by reads

    // core-domain state
    logic [`DBGWP_SYNC_BITS-1:0] s1_q;       // first synchroniser stage
    logic [`DBGWP_SYNC_BITS-1:0] s2_q;       // second stage
    logic [`DBGWP_SYNC_BITS-1:0] s3_q;       // third stage
    logic [`DBGWP_SYNC_BITS-1:0] sy_q;       // agreed value
    logic [`DBGWP_SYNC_BITS-1:0] sync_in;    // bits crossing into clk
    logic                        hit_q;      // registered comparator hit
    logic                        halt_q;     // halt entry pulse
    logic                        abort_q;    // abort entry pulse

    logic [1:0] wp_match;                    // per-unit match
    logic [1:0] wp_range;                    // per-unit range output
    logic [1:0] wp_chain;                    // per-unit chain output
    logic       dis_clk;                     // comparators disabled, clk
    logic       mon_clk;                     // monitor mode, clk
    logic       inh_clk;                     // interrupt inhibit, clk
    logic       req_clk;                     // forced halt request, clk
    logic       ack_clk;                     // forced acknowledge, clk
    logic       ext_req_clk;                 // halt request pin, clk

    // debug control register write, reserved bit kept at zero
    always_ff @(posedge tck or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q <= `DBGWP_CTRL_RESET;
        end
        else if (scan_update && scan_req.write && scan_req.addr == `DBGWP_ADDR_CTRL)
        begin
            ctrl_q <= scan_req.data[`DBGWP_CTRL_W-1:0] & `DBGWP_CTRL_RSV_MSK;
        end
    end

    // watchpoint register writes, one slice per unit
    generate
        for (genvar u = 0; u < 2; u++)
        begin : g_wp
            logic sel; // this unit addressed by the write
            assign sel = scan_update && scan_req.write
                      && scan_req.addr[4:3] == ((u == 0) ? `DBGWP_ADDR_WP0 : `DBGWP_ADDR_WP1);

            // registers are quasi-static: the debugger parks bit 5 around writes
            always_ff @(posedge tck or posedge reset)
            begin
                if (reset)
                begin
                    wp_q[u] <= '0;
                end
                else if (sel)
                begin
                    case (scan_req.addr[2:0])
                        `DBGWP_IDX_AV: wp_q[u].addr_val  <= scan_req.data;
                        `DBGWP_IDX_AM: wp_q[u].addr_mask <= scan_req.data;
                        `DBGWP_IDX_DV: wp_q[u].data_val  <= scan_req.data;
                        `DBGWP_IDX_DM: wp_q[u].data_mask <= scan_req.data;
                        `DBGWP_IDX_CV: wp_q[u].ctrl_val  <= scan_req.data[8:0];
                        `DBGWP_IDX_CM: wp_q[u].ctrl_mask <= scan_req.data[7:0];
                        default:       wp_q[u]           <= wp_q[u]; // unmapped index
                    endcase
                end
            end
        end
    endgenerate

    // forced halt request passes its latch only in run-test/idle, so several
    // cores can be armed and then released together
    always_ff @(posedge tck or posedge reset)
    begin
        if (reset)
        begin
            req_latch_q <= 1'b0;
        end
        else if (scan_run_idle)
        begin
            req_latch_q <= ctrl_q[`DBGWP_CB_HALT_REQ];
        end
    end

    // bit 5 comes back from the core domain before reads report it
    always_ff @(posedge tck or posedge reset)
    begin
        if (reset)
        begin
            dis_back_q <= 3'h0;
            dis_tck_q  <= 1'b0;
        end
        else
        begin
            dis_back_q <= {dis_back_q[1:0], dis_clk};
            if (dis_back_q[1] == dis_back_q[2])
            begin
                dis_tck_q <= dis_back_q[2];
            end
        end
    end

    // read data captured at update, unmapped addresses read zero
    always_ff @(posedge tck or posedge reset)
    begin
        if (reset)
        begin
            scan_rdata <= 32'h0000_0000;
        end
        else if (scan_update && !scan_req.write)
        begin
            scan_rdata <= 32'h0000_0000;
            if (scan_req.addr == `DBGWP_ADDR_CTRL)
            begin
                scan_rdata[`DBGWP_CTRL_W-1:0] <= {dis_tck_q, ctrl_q[4:0]};
            end
            else
            begin
                for (int u = 0; u < 2; u++)
                begin
                    if (scan_req.addr[4:3] == ((u == 0) ? `DBGWP_ADDR_WP0 : `DBGWP_ADDR_WP1))
                    begin
                        case (scan_req.addr[2:0])
                            `DBGWP_IDX_AV: scan_rdata <= wp_q[u].addr_val;
                            `DBGWP_IDX_AM: scan_rdata <= wp_q[u].addr_mask;
                            `DBGWP_IDX_DV: scan_rdata <= wp_q[u].data_val;
                            `DBGWP_IDX_DM: scan_rdata <= wp_q[u].data_mask;
                            `DBGWP_IDX_CV: scan_rdata <= {23'h000000, wp_q[u].ctrl_val};
                            `DBGWP_IDX_CM: scan_rdata <= {24'h000000, wp_q[u].ctrl_mask};
                            default:       scan_rdata <= 32'h0000_0000;
                        endcase
                    end
                end
            end
        end
    end

    // bits crossing into the core clock
    assign sync_in = {ext_halt_request,
                      ctrl_q[`DBGWP_CB_DISABLE],
                      ctrl_q[`DBGWP_CB_MONITOR],
                      ctrl_q[`DBGWP_CB_INT_INH],
                      req_latch_q,
                      ctrl_q[`DBGWP_CB_HALT_ACK]};

    // three stages and an agreed flop per bit; a new level counts once stages two and three agree
    generate
        for (genvar b = 0; b < `DBGWP_SYNC_BITS; b++)
        begin : g_sync
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    s1_q[b] <= 1'b0;
                    s2_q[b] <= 1'b0;
                    s3_q[b] <= 1'b0;
                    sy_q[b] <= 1'b0;
                end
                else
                begin
                    s1_q[b] <= sync_in[b];
                    s2_q[b] <= s1_q[b];
                    s3_q[b] <= s2_q[b];
                    if (s2_q[b] == s3_q[b])
                    begin
                        sy_q[b] <= s3_q[b];
                    end
                end
            end
        end
    endgenerate

    assign {ext_req_clk, dis_clk, mon_clk, inh_clk, req_clk, ack_clk} = sy_q;

    // unit 1 feeds chain and range into unit 0; unit 1 has neither input
    dbgwp_unit u_wp0 (
        .clk       (clk),
        .reset     (reset),
        .regs      (wp_q[0]),
        .bus       (core_bus),
        .extern_in (extern_in[0]),
        .chain_in  (wp_chain[1]),
        .range_in  (wp_range[1]),
        .match     (wp_match[0]),
        .range_out (wp_range[0]),
        .chain_out (wp_chain[0])
    );

    dbgwp_unit u_wp1 (
        .clk       (clk),
        .reset     (reset),
        .regs      (wp_q[1]),
        .bus       (core_bus),
        .extern_in (extern_in[1]),
        .chain_in  (1'b0),
        .range_in  (1'b0),
        .match     (wp_match[1]),
        .range_out (wp_range[1]),
        .chain_out (wp_chain[1])
    );

    // comparator hit, suppressed while the disable bit is in force
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hit_q <= 1'b0;
        end
        else
        begin
            hit_q <= (|wp_match) & ~dis_clk;
        end
    end

    // hit routes to halt or abort; one pulse per rising hit
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            halt_q  <= 1'b0;
            abort_q <= 1'b0;
        end
        else
        begin
            halt_q  <= (|wp_match) & ~dis_clk & ~hit_q & ~mon_clk;
            abort_q <= (|wp_match) & ~dis_clk & ~hit_q & mon_clk;
        end
    end

    assign break_halt  = halt_q;
    assign break_abort = abort_q;

    // halt handshake and interrupt permit, from synchronised levels and the unsynchronised core acknowledge
    assign halt_request          = req_clk | ext_req_clk;
    assign halt_acknowledge      = core_halt_ack_int | ack_clk;
    assign core_interrupt_permit = ~halt_acknowledge & ~inh_clk;

    // note: permit depends on acknowledge, so a forced ack also blocks interrupts

endmodule // dbgwp_top
`default_nettype wire

// File: testbench/dbgwp_sva.sv
// Purpose: port checks of the debug control block
// Assumes: one reset clears both domains
// Notes:   bound into every dbgwp_top instance
`timescale 1ns/10ps
`default_nettype none
module dbgwp_sva
    import dbgwp_pkg::*;
(
    input wire logic         clk,
    input wire logic         reset,
    input wire logic         tck,
    input wire logic         scan_update,
    input var  dbgwp_scan_t  scan_req,
    input wire logic [31:0]  scan_rdata,
    input wire logic         ext_halt_request,
    input wire logic         core_halt_ack_int,
    input wire logic         halt_request,
    input wire logic         halt_acknowledge,
    input wire logic         core_interrupt_permit,
    input wire logic         break_halt,
    input wire logic         break_abort
);
    // core ack shows at the pin
    ack_pass_a: assert property (@(posedge clk) disable iff (reset)
        core_halt_ack_int |-> halt_acknowledge) else $error("ack not passed out");
    // no interrupts during ack
    permit_ack_a: assert property (@(posedge clk) disable iff (reset)
        halt_acknowledge |-> !core_interrupt_permit) else $error("permit during ack");
    // a hit is a single-cycle pulse
    halt_pulse_a: assert property (@(posedge clk) disable iff (reset)
        break_halt |=> !break_halt) else $error("halt pulse too long");
    abort_pulse_a: assert property (@(posedge clk) disable iff (reset)
        break_abort |=> !break_abort) else $error("abort pulse too long");
    // halt and abort exclusive
    hit_excl_a: assert property (@(posedge clk) disable iff (reset)
        !(break_halt && break_abort)) else $error("halt and abort together");
    // read data moves only on reads
    rdata_hold_a: assert property (@(posedge tck) disable iff (reset)
        !(scan_update && !scan_req.write) |=> $stable(scan_rdata))
        else $error("read data moved");
    // control reads six bits, bit 3 clear
    ctrl_rd_a: assert property (@(posedge tck) disable iff (reset)
        scan_update && !scan_req.write && scan_req.addr == 5'h00
        |=> scan_rdata[31:6] == 26'h0 && !scan_rdata[3]) else $error("control read wide");
    // unmapped places read as zero
    unmap_rd_a: assert property (@(posedge tck) disable iff (reset)
        scan_update && !scan_req.write && (scan_req.addr == 5'h07 || scan_req.addr == 5'h0E)
        |=> scan_rdata == 32'h0) else $error("unmapped read not zero");
    // pin request passes its synchroniser
    pin_req_a: assert property (@(posedge clk) disable iff (reset)
        $rose(ext_halt_request) |-> ##[1:5] halt_request) else $error("pin request lost");
    cov_halt: cover property (@(posedge clk) disable iff (reset) break_halt);
    cov_abort: cover property (@(posedge clk) disable iff (reset) break_abort);
    cov_req: cover property (@(posedge clk) disable iff (reset)
        halt_request && !ext_halt_request);
endmodule // dbgwp_sva
bind dbgwp_top dbgwp_sva u_dbgwp_sva (.clk, .reset, .tck, .scan_update, .scan_req,
    .scan_rdata, .ext_halt_request, .core_halt_ack_int, .halt_request, .halt_acknowledge,
    .core_interrupt_permit, .break_halt, .break_abort);
`default_nettype wire

// File: testbench/dbgwp_dbg_model.sv
// Purpose: debugger model on the scan port
// Assumes: tck stands still between accesses
// Notes:   tasks called from the bench
`timescale 1ns/10ps
`default_nettype none
module dbgwp_dbg_model
    import dbgwp_pkg::*;
(
    output logic             tck,           // scan clock, only in accesses
    output logic             scan_update,   // update strobe
    output logic             scan_run_idle, // idle level
    output dbgwp_scan_t      scan_req,      // shifted access
    input  wire logic [31:0] scan_rdata     // read data
);
    logic [5:0] ctrl_cur;  // last control value
    initial
    begin
        tck = 1'b0;
        scan_update = 1'b0;
        scan_run_idle = 1'b0;
        scan_req = '0;
        ctrl_cur = 6'h00;
    end
    // one tck cycle, inputs move at the rise
    task automatic step(input logic upd, input logic idl, input dbgwp_scan_t r);
        #40 tck = 1'b1;
        scan_update <= upd;
        scan_run_idle <= idl;
        scan_req <= r;
        #40 tck = 1'b0;
    endtask
    // released fields show their inverse
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        step(1'b1, 1'b0, '{1'b1, a, d});
        step(1'b0, 1'b0, ~scan_req);
    endtask
    // data taken a cycle after the update
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        step(1'b1, 1'b0, '{1'b0, a, 32'h0});
        step(1'b0, 1'b0, ~scan_req);
        step(1'b0, 1'b0, ~scan_req);
        d = scan_rdata;
    endtask
    // write then read back the same place
    task automatic wrrd(input logic [4:0] a, input logic [31:0] w, output logic [31:0] d);
        wr(a, w);
        rd(a, d);
    endtask
    // idle cycles open the halt latch
    task automatic idle(input int n);
        repeat (n) step(1'b0, 1'b1, ~scan_req);
        step(1'b0, 1'b0, ~scan_req);
    endtask
    // write, then poll: bit 5 returns late
    task automatic set_ctrl(input logic [5:0] v, output logic ok);
        logic [31:0] d;
        ok = 1'b0;
        wr(5'h00, {26'h0, v & 6'h37});
        repeat (12)
        begin
            if (ok !== 1'b1)
            begin
                rd(5'h00, d);
                ok = (d[5:0] == (v & 6'h37));
            end
        end
        ctrl_cur = v;
    endtask
    // unit programming inside the disable
    task automatic prog(input logic [4:0] base, input dbgwp_regs_t g, output logic ok);
        logic ok1;
        set_ctrl(ctrl_cur | 6'h20, ok1);
        wr(base, g.addr_val);
        wr(base + 5'd1, g.addr_mask);
        wr(base + 5'd2, g.data_val);
        wr(base + 5'd3, g.data_mask);
        wr(base + 5'd4, {23'h0, g.ctrl_val});
        wr(base + 5'd5, {24'h0, g.ctrl_mask});
        set_ctrl(ctrl_cur & 6'h1F, ok);
        ok = ok & ok1;
    endtask
endmodule // dbgwp_dbg_model
`default_nettype wire

// File: testbench/dbgwp_top_tb_top.sv
// Purpose: bench of the debug control block
// Assumes: model owns tck, bench owns clk side
// Notes:   waits cover the clk synchroniser
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module dbgwp_top_tb_top
    import dbgwp_pkg::*;
;
    logic        clk, reset, tck, scan_update, scan_run_idle;   // clocks, strobes
    dbgwp_scan_t scan_req;                                      // scan access
    logic [31:0] scan_rdata;                                    // scan read data
    dbgwp_bus_t  core_bus, idle_bus;                            // core bus, quiet value
    logic [1:0]  extern_in;                                     // masked in every setup
    logic        ext_halt_request, core_halt_ack_int;           // halt pin, core ack
    logic        halt_request, halt_acknowledge;                // halt outputs
    logic        core_interrupt_permit, break_halt, break_abort; // core controls
    int          fail_count, n_tests, cycles;                   // run counters
    dbgwp_top u_dbgwp_top (.clk, .reset, .tck, .scan_update, .scan_run_idle, .scan_req,
        .scan_rdata, .core_bus, .extern_in, .ext_halt_request, .core_halt_ack_int,
        .halt_request, .halt_acknowledge, .core_interrupt_permit, .break_halt, .break_abort);
    dbgwp_dbg_model u_dbgwp_dbg_model (.tck, .scan_update, .scan_run_idle, .scan_req,
        .scan_rdata);
    // core clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // c = {data access, write, size, priv, 16-bit}
    function automatic dbgwp_bus_t mk(input logic [31:0] a, d, input logic [5:0] c);
        mk = {a, d, c};
    endfunction
    // control write, then let clk side catch up
    task automatic ctl(input logic [5:0] v);
        logic ok;
        u_dbgwp_dbg_model.set_ctrl(v, ok);
        `CHK(ok, 1'b1);
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic pg(input logic [4:0] base, input dbgwp_regs_t g);
        logic ok;
        u_dbgwp_dbg_model.prog(base, g, ok);
        `CHK(ok, 1'b1);
        repeat (8) @(posedge clk);
    endtask
    // bus cycle held: pulse e = {halt, abort} next cycle, then none
    task automatic hit(input dbgwp_bus_t b, input logic [1:0] e);
        @(posedge clk);
        core_bus <= b;
        @(posedge clk);
        @(negedge clk);
        `CHK(break_halt, e[1]);
        `CHK(break_abort, e[0]);
        @(negedge clk);
        `CHK(break_halt | break_abort, 1'b0);
        @(posedge clk);
        core_bus <= idle_bus;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_reset();
        logic [31:0] d;
        @(negedge clk);
        `CHK(halt_request, 1'b0);
        `CHK(core_interrupt_permit, 1'b1);
        @(posedge clk);
        core_halt_ack_int <= 1'b1;
        @(negedge clk);
        `CHK({halt_acknowledge, core_interrupt_permit}, 2'b10);
        @(posedge clk);
        core_halt_ack_int <= 1'b0;
        u_dbgwp_dbg_model.rd(5'h00, d);
        `CHK(d, 32'h0);
        u_dbgwp_dbg_model.wrrd(5'h00, 32'h0000_0008, d);
        `CHK(d, 32'h0);
    endtask
    // widths and unmapped places, comparators off
    task automatic t_regs();
        logic [31:0] d;
        logic [4:0]  b;
        ctl(6'h20);
        for (int u = 1; u <= 2; u++)
        begin
            b = 5'(u * 8);
            u_dbgwp_dbg_model.wrrd(b, 32'hA5A5_5A5A, d);
            `CHK(d, 32'hA5A5_5A5A);
            u_dbgwp_dbg_model.wrrd(b + 5'd4, 32'hFFFF_FFFF, d);
            `CHK(d, 32'h0000_01FF);
            u_dbgwp_dbg_model.wr(b + 5'd4, 32'h0);
            u_dbgwp_dbg_model.wrrd(b + 5'd5, 32'hFFFF_FFFF, d);
            `CHK(d, 32'h0000_00FF);
            u_dbgwp_dbg_model.wrrd(b + 5'd6, 32'hFFFF_FFFF, d);
            `CHK(d, 32'h0);
        end
        u_dbgwp_dbg_model.rd(5'h07, d);
        `CHK(d, 32'h0);
        ctl(6'h00);
    endtask
    task automatic t_hw();
        dbgwp_bus_t f;
        f = mk(32'h1000, 32'h0, 6'h08);
        pg(5'h08, '{32'h1000, 32'h3, 32'h0, 32'hFFFF_FFFF, 9'h100, 8'hF7});
        hit(f, 2'b10);
        hit(mk(32'h1002, 32'h0, 6'h08), 2'b10);
        hit(mk(32'h1004, 32'h0, 6'h08), 2'b00);
        hit(mk(32'h1000, 32'h0, 6'h28), 2'b00);
        ctl(6'h20);
        ctl(6'h30);
        ctl(6'h10);
        hit(f, 2'b01);
        ctl(6'h30);
        hit(f, 2'b00);
        ctl(6'h20);
        ctl(6'h00);
    endtask
    task automatic t_sw();
        pg(5'h10, '{32'h0, 32'hFFFF_FFFF, 32'hA5C3_A5C3, 32'h0, 9'h100, 8'hF7});
        hit(mk(32'h2002, 32'hA5C3_1234, 6'h05), 2'b10);
        hit(mk(32'h2000, 32'hA5C3_1234, 6'h05), 2'b00);
        hit(mk(32'h2000, 32'h7777_A5C3, 6'h05), 2'b10);
    endtask
    task automatic t_wp();
        pg(5'h08, '{32'h3000, 32'h0, 32'h0, 32'hFFFF_FFFF, 9'h10D, 8'hF0});
        hit(mk(32'h3000, 32'h5A, 6'h38), 2'b10);
        hit(mk(32'h3000, 32'h5A, 6'h28), 2'b00);
        hit(mk(32'h3000, 32'h5A, 6'h34), 2'b00);
        hit(mk(32'h3004, 32'h5A, 6'h38), 2'b00);
        pg(5'h08, '{32'h3000, 32'h0, 32'h0, 32'hFFFF_FFFF, 9'h10D, 8'hF1});
        hit(mk(32'h3000, 32'h5A, 6'h28), 2'b10);
    endtask
    // forced halt controls; request waits for idle
    task automatic t_halt();
        ctl(6'h04);
        `CHK({core_interrupt_permit, halt_acknowledge}, 2'b00);
        ctl(6'h01);
        `CHK({core_interrupt_permit, halt_acknowledge}, 2'b01);
        ctl(6'h02);
        `CHK(halt_request, 1'b0);
        u_dbgwp_dbg_model.idle(2);
        ctl(6'h02);
        `CHK(halt_request, 1'b1);
        ctl(6'h00);
        `CHK({core_interrupt_permit, halt_request}, 2'b11);
        u_dbgwp_dbg_model.idle(2);
        ctl(6'h00);
        `CHK(halt_request, 1'b0);
        @(posedge clk);
        ext_halt_request <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        `CHK(halt_request, 1'b1);
        ext_halt_request <= 1'b0;
    endtask
    initial
    begin
        reset = 1'b1;
        extern_in = 2'b00;
        ext_halt_request = 1'b0;
        core_halt_ack_int = 1'b0;
        idle_bus = mk(32'hFFFF_FFF0, 32'h0, 6'h2C);
        core_bus = idle_bus;
        fail_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_regs();
        t_hw();
        t_sw();
        t_wp();
        t_halt();
        end_sim();
    end
endmodule // dbgwp_top_tb_top
`default_nettype wire
